/* hw/vrr_engine.sv */
// region block read engine: config tables, checks and transfer control
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module vrr_engine (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// register port
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	// request
	input wire logic reqEnable,
	input wire logic [2:0] reqRack,
	input wire logic [4:0] reqSlot,
	input wire logic [3:0] reqSubslot,
	input wire logic reqSubslotGiven,
	input wire logic [3:0] reqRegion,
	input wire logic reqRegionGiven,
	input wire logic [31:0] reqOffset,
	input wire logic [15:0] reqUnitCount,
	input wire logic [1:0] reqUnitSize,
	input wire logic [15:0] reqDest,
	// result
	output logic busy,
	output logic success,
	output logic [3:0] completionCode,
	// host memory
	output logic memWrite,
	output logic [15:0] memAddr,
	output logic [31:0] memData,
	output logic [1:0] memUnitSize,
	// backplane
	output logic busReq,
	output logic [31:0] busAddr,
	output logic [1:0] busUnitSize,
	output logic busBurst,
	output logic busWideBurst,
	output logic busAm16,
	input wire logic busAckPin,
	input wire logic busErrPin,
	input wire logic [31:0] busData
);
	import vrr_pkg::*;

	////////////////////////////////////////////////////////////////////
	// configuration tables
	logic [MOD_W-1:0] modCfg [ENTRIES];
	logic [31:0] areaBase [ENTRIES*REGIONS];
	logic [SIZE_W-1:0] areaSize [ENTRIES*REGIONS];
	logic [ATTR_W-1:0] areaAttr [ENTRIES*REGIONS];
	wire [3:0] regKind = regAddr[11:8];
	wire [RIDX_W-1:0] regIdx = regAddr[RIDX_W-1:0];
	wire modSel = regAddr[5:3] == 3'h0;

	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int k = 0; k < ENTRIES*REGIONS; k++) begin
				areaBase[k] <= 32'h0000_0000;
				areaSize[k] <= SIZE_RST;
				areaAttr[k] <= ATTR_RST;
			end
			for (int k = 0; k < ENTRIES; k++) begin
				modCfg[k] <= '0;
			end
		end else if (regWr) begin
			// overlapping spans are stored as given, never checked
			case (regKind)
				KIND_MOD: begin
					if (modSel) begin
						modCfg[regIdx[2:0]] <= regWdata[MOD_W-1:0];
					end
				end
				KIND_BASE: areaBase[regIdx] <= regWdata;
				KIND_SIZE: areaSize[regIdx] <= regWdata[SIZE_W-1:0];
				KIND_ATTR: areaAttr[regIdx] <= regWdata[ATTR_W-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// register read path
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0000_0000;
		case (regKind)
			KIND_MOD: begin
				if (modSel) begin
					rdMux = {17'h0_0000, modCfg[regIdx[2:0]]};
				end
			end
			KIND_BASE: rdMux = areaBase[regIdx];
			KIND_SIZE: rdMux = {7'h00, areaSize[regIdx]};
			KIND_ATTR: rdMux = {26'h000_0000, areaAttr[regIdx]};
			KIND_STAT: rdMux = {26'h000_0000, busy, success, completionCode};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst || !regRd) begin
			regRdata <= 32'h0000_0000;
		end else begin
			regRdata <= rdMux;
		end
	end

	////////////////////////////////////////////////////////////////////
	// backplane handshake pins
	logic [SYNC_W-1:0] syncPins;
	vrr_pin_sync u_sync (
		.mclk(mclk),
		.srst(srst),
		.pinIn({busErrPin, busAckPin}),
		.level(syncPins)
	);
	wire ackSync = syncPins[0];
	wire errSync = syncPins[1];

	////////////////////////////////////////////////////////////////////
	// captured request
	vrr_state_t state;
	logic [2:0] capRack;
	logic [4:0] capSlot;
	logic [3:0] capSub;
	logic [3:0] capRegion;
	logic [31:0] capOffset;
	logic [15:0] capCount;
	logic [1:0] capSize;
	logic [15:0] remaining;
	logic [2:0] stride;

	wire takeReq = state == S_IDLE && reqEnable;
	wire [3:0] next_sub = reqSubslotGiven ? reqSubslot : DEF_SUBSLOT;
	wire [3:0] next_region = reqRegionGiven ? reqRegion : DEF_REGION;

	////////////////////////////////////////////////////////////////////
	// module lookup, one comparator per entry
	logic [ENTRIES-1:0] hitVec;
	genvar e;
	generate
		for (e = 0; e < ENTRIES; e++) begin : g_ent
			// same selection fields serve every operation kind
			assign hitVec[e] = modCfg[e][MOD_PRESENT]
				&& modCfg[e][MOD_RACK_LSB+:3] == capRack
				&& modCfg[e][MOD_SLOT_LSB+:5] == capSlot
				&& modCfg[e][MOD_SUB_LSB+:4] == capSub;
		end
	endgenerate

	logic [2:0] entIdx;
	logic anyArea;
	always_comb begin
		entIdx = 3'h0;
		for (int k = ENTRIES - 1; k >= 0; k--) begin
			if (hitVec[k]) begin
				entIdx = 3'(k);
			end
		end
		anyArea = 1'b0;
		for (int k = 0; k < REGIONS; k++) begin
			anyArea = anyArea | areaAttr[{entIdx, 3'(k)}][ATTR_EN];
		end
	end

	////////////////////////////////////////////////////////////////////
	// region selection and span checks
	wire [2:0] rIdx = 3'(capRegion - 4'h1);
	// modules sharing one slot differ in subslot, each with its own entry
	wire [RIDX_W-1:0] tIdx = {entIdx, rIdx};
	wire [ATTR_W-1:0] attr = areaAttr[tIdx];
	wire [2:0] ifType = attr[ATTR_IF_LSB+:3];
	wire isExp = modCfg[entIdx][MOD_EXP];
	wire [31:0] absAddr = areaBase[tIdx] + capOffset;
	wire [2:0] unitBytes = 3'h1 << capSize;
	wire oddOnly = ifType == IF_ODD;
	wire fixedAddr = ifType == IF_SWORD || ifType == IF_SBYTE;
	// odd-only steps by two so every unit starts on an odd address
	wire [2:0] next_stride = oddOnly ? 3'h2 :
		fixedAddr ? 3'h0 : unitBytes;
	wire [17:0] stepSpan = 18'(capCount - 16'h1) * 18'(next_stride);
	wire [33:0] firstOff = {2'h0, capOffset};
	wire [33:0] lastOff = firstOff + 34'(stepSpan) + 34'(unitBytes - 3'h1);
	wire [33:0] sizeExt = 34'(areaSize[tIdx]);
	wire paramBad = capCount == 16'h0000 || capCount > MAX_COUNT
		|| capRegion == 4'h0 || capRegion > 4'(REGIONS)
		|| capSize > USZ_DWORD;
	// bursts never on A16 or expansion racks
	wire burstOk = attr[ATTR_BURST] && !attr[ATTR_A16] && !isExp;
	wire wideOk = burstOk && ifType == IF_QWORD;

	logic [3:0] checkCode;
	always_comb begin
		if (paramBad) begin
			checkCode = CODE_PARAM;
		end else if (hitVec == '0) begin
			checkCode = CODE_NOMOD;
		end else if (!modCfg[entIdx][MOD_TYPE_OK]) begin
			checkCode = CODE_TYPE;
		end else if (!anyArea || !attr[ATTR_EN]) begin
			checkCode = CODE_NOREG;
		end else if (firstOff >= sizeExt) begin
			checkCode = CODE_START;
		end else if (lastOff >= sizeExt) begin
			checkCode = CODE_END;
		end else if (oddOnly && !absAddr[0]) begin
			checkCode = CODE_ODD;
		end else begin
			checkCode = CODE_OK;
		end
	end

	////////////////////////////////////////////////////////////////////
	// request capture
	always_ff @(posedge mclk) begin
		if (srst) begin
			capRack <= 3'h0;
			capSlot <= 5'h00;
			capSub <= 4'h0;
			capRegion <= 4'h0;
			capOffset <= 32'h0000_0000;
			capCount <= 16'h0000;
			capSize <= USZ_BYTE;
		end else if (takeReq) begin
			// selections sampled only in the enabled cycle
			capRack <= reqRack;
			capSlot <= reqSlot;
			capSub <= next_sub;
			capRegion <= next_region;
			capOffset <= reqOffset;
			capCount <= reqUnitCount;
			capSize <= reqUnitSize;
		end
	end

	////////////////////////////////////////////////////////////////////
	// transfer sequencer
	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= S_IDLE;
			busy <= 1'b0;
			success <= 1'b0;
			completionCode <= CODE_OK;
			busReq <= 1'b0;
			busAddr <= 32'h0000_0000;
			busUnitSize <= USZ_BYTE;
			busBurst <= 1'b0;
			busWideBurst <= 1'b0;
			busAm16 <= 1'b0;
			memWrite <= 1'b0;
			memAddr <= 16'h0000;
			memData <= 32'h0000_0000;
			memUnitSize <= USZ_BYTE;
			remaining <= 16'h0000;
			stride <= 3'h0;
		end else begin
			memWrite <= 1'b0;
			case (state)
				S_IDLE: begin
					if (takeReq) begin
						busy <= 1'b1;
						memAddr <= reqDest;
						memUnitSize <= reqUnitSize;
						state <= S_CHECK;
					end
				end
				S_CHECK: begin
					if (checkCode != CODE_OK) begin
						// no bus cycle on a failed
						completionCode <= checkCode;
						success <= 1'b0;
						busy <= 1'b0;
						state <= S_IDLE;
					end else begin
						busAddr <= absAddr;
						busUnitSize <= capSize;
						busBurst <= burstOk;
						busWideBurst <= wideOk;
						busAm16 <= attr[ATTR_A16];
						stride <= next_stride;
						remaining <= capCount;
						busReq <= 1'b1;
						state <= S_WAIT_ACK;
					end
				end
				S_WAIT_ACK: begin
					if (errSync) begin
						// abort, rest of the block is dropped
						busReq <= 1'b0;
						completionCode <= CODE_BUSERR;
						success <= 1'b0;
						busy <= 1'b0;
						state <= S_IDLE;
					end else if (ackSync) begin
						// data held by the module while ack stands
						busReq <= 1'b0;
						memData <= busData;
						memWrite <= 1'b1;
						remaining <= remaining - 16'h0001;
						state <= S_WAIT_REL;
					end
				end
				S_WAIT_REL: begin
					if (!ackSync) begin
						if (remaining == 16'h0000) begin
							// result only once the last unit is stored
							completionCode <= CODE_OK;
							success <= 1'b1;
							busy <= 1'b0;
							state <= S_IDLE;
						end else begin
							busAddr <= busAddr + 32'(stride);
							memAddr <= memAddr + 16'h0001;
							busReq <= 1'b1;
							state <= S_WAIT_ACK;
						end
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule

/* hw/vrr_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module vrr_pin_sync (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// pins and clean levels
	input wire logic [vrr_pkg::SYNC_W-1:0] pinIn,
	output logic [vrr_pkg::SYNC_W-1:0] level
);
	import vrr_pkg::*;
	logic [SYNC_W-1:0] s1;
	logic [SYNC_W-1:0] s2;
	logic [SYNC_W-1:0] s3;
	genvar i;
	generate
		for (i = 0; i < SYNC_W; i++) begin : g_bit
			always_ff @(posedge mclk) begin
				if (srst) begin
					s1[i] <= 1'b0;
					s2[i] <= 1'b0;
					s3[i] <= 1'b0;
					level[i] <= 1'b0;
				end else begin
					s1[i] <= pinIn[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					// s1 is left alone; only the later stages vote
					if (s2[i] == s3[i]) begin
						level[i] <= s3[i];
					end
				end
			end
		end
	endgenerate
endmodule

/* include/vrr_pkg.sv */
// constants, field layouts and states of the region block read engine
package vrr_pkg;
	localparam int ENTRIES = 8;
	localparam int REGIONS = 8;
	localparam int RIDX_W = 6;
	localparam int SIZE_W = 25;
	localparam int MOD_W = 15;
	localparam int ATTR_W = 6;
	localparam int SYNC_W = 2;
	// register index map, kind in bits 11:8, entry in 5:0
	localparam logic [3:0] KIND_MOD = 4'h0;
	localparam logic [3:0] KIND_BASE = 4'h1;
	localparam logic [3:0] KIND_SIZE = 4'h2;
	localparam logic [3:0] KIND_ATTR = 4'h3;
	localparam logic [3:0] KIND_STAT = 4'h4;
	// module entry fields
	localparam int MOD_RACK_LSB = 0;
	localparam int MOD_SLOT_LSB = 3;
	localparam int MOD_SUB_LSB = 8;
	localparam int MOD_EXP = 12;
	localparam int MOD_TYPE_OK = 13;
	localparam int MOD_PRESENT = 14;
	// region attribute fields
	localparam int ATTR_EN = 0;
	localparam int ATTR_BURST = 1;
	localparam int ATTR_IF_LSB = 2;
	localparam int ATTR_A16 = 5;
	// interface types
	localparam logic [2:0] IF_QWORD = 3'h0;
	localparam logic [2:0] IF_DWORD = 3'h1;
	localparam logic [2:0] IF_WORD = 3'h2;
	localparam logic [2:0] IF_BYTE = 3'h3;
	localparam logic [2:0] IF_ODD = 3'h4;
	localparam logic [2:0] IF_SWORD = 3'h5;
	localparam logic [2:0] IF_SBYTE = 3'h6;
	// unit sizes
	localparam logic [1:0] USZ_BYTE = 2'h0;
	localparam logic [1:0] USZ_WORD = 2'h1;
	localparam logic [1:0] USZ_DWORD = 2'h2;
	// reset values, request defaults and count limit
	localparam logic [SIZE_W-1:0] SIZE_RST = 25'h000_0800;
	localparam logic [ATTR_W-1:0] ATTR_RST = 6'h08;
	localparam logic [3:0] DEF_SUBSLOT = 4'h0;
	localparam logic [3:0] DEF_REGION = 4'h1;
	localparam logic [15:0] MAX_COUNT = 16'h7FFF;
	// completion codes
	localparam logic [3:0] CODE_OK = 4'h0;
	localparam logic [3:0] CODE_BUSERR = 4'h1;
	localparam logic [3:0] CODE_NOMOD = 4'h2;
	localparam logic [3:0] CODE_TYPE = 4'h3;
	localparam logic [3:0] CODE_START = 4'h4;
	localparam logic [3:0] CODE_END = 4'h5;
	localparam logic [3:0] CODE_ODD = 4'h6;
	localparam logic [3:0] CODE_NOREG = 4'h8;
	localparam logic [3:0] CODE_PARAM = 4'hA;
	typedef enum logic [1:0] {
		S_IDLE,
		S_CHECK,
		S_WAIT_ACK,
		S_WAIT_REL
	} vrr_state_t;
endpackage

/* verif/vrr_bus_model.sv */
// backplane module model answering the engine's bus cycles
`timescale 1ns/100ps
module vrr_bus_model (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// behaviour controls
	input wire logic [3:0] ackDelay,
	input wire logic errMode,
	// backplane
	input wire logic busReq,
	input wire logic [31:0] busAddr,
	output logic busAckPin,
	output logic busErrPin,
	output logic [31:0] busData
);
	logic [3:0] waitCnt;
	always @(posedge mclk) begin
		if (srst || !busReq) begin
			waitCnt <= 4'h0;
			busAckPin <= 1'b0;
			busErrPin <= 1'b0;
			// released lines drift so a stale word never passes
			busData <= srst ? 32'h0000_0000 : ~busData;
		end else if (waitCnt < ackDelay) begin
			waitCnt <= waitCnt + 4'h1;
		end else if (errMode) begin
			busErrPin <= 1'b1;
		end else begin
			busAckPin <= 1'b1;
			// word tied to address: each decoded range reads apart
			busData <= {busAddr[15:0], ~busAddr[15:0]};
		end
	end
endmodule

/* verif/vrr_engine_tb.sv */
// self-checking bench for the region block read engine
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value at %0t: %h, expected %h", $time, g, e); end end
module vrr_engine_tb;
	import vrr_pkg::*;
	typedef struct packed {
		logic [4:0] s;
		logic [3:0] ss;
		logic [3:0] r;
		logic g;
		logic [11:0] o;
		logic [15:0] n;
		logic [1:0] u;
		logic [3:0] c;
	} vrr_row_t;
	localparam vrr_row_t ROWS [14] = '{
		'{5'h02, 4'h5, 4'h5, 1'h0, 12'h004, 16'h0002, USZ_WORD, CODE_OK},
		'{5'h02, 4'h0, 4'h1, 1'h1, 12'h0FC, 16'h0002, USZ_WORD, CODE_OK},
		'{5'h02, 4'h0, 4'h2, 1'h1, 12'h001, 16'h0002, USZ_BYTE, CODE_OK},
		'{5'h02, 4'h0, 4'h2, 1'h1, 12'h002, 16'h0001, USZ_BYTE, CODE_ODD},
		'{5'h02, 4'h0, 4'h1, 1'h1, 12'h100, 16'h0001, USZ_WORD, CODE_START},
		'{5'h02, 4'h0, 4'h1, 1'h1, 12'h0FE, 16'h0002, USZ_WORD, CODE_END},
		'{5'h02, 4'h0, 4'h1, 1'h1, 12'h000, 16'h0000, USZ_WORD, CODE_PARAM},
		'{5'h02, 4'h0, 4'h1, 1'h1, 12'h000, 16'h8000, USZ_BYTE, CODE_PARAM},
		'{5'h02, 4'h0, 4'h1, 1'h1, 12'h000, 16'h0001, 2'h3, CODE_PARAM},
		'{5'h09, 4'h0, 4'h1, 1'h1, 12'h000, 16'h0001, USZ_WORD, CODE_NOMOD},
		'{5'h03, 4'h0, 4'h1, 1'h1, 12'h000, 16'h0001, USZ_WORD, CODE_TYPE},
		'{5'h04, 4'h0, 4'h1, 1'h1, 12'h000, 16'h0001, USZ_WORD, CODE_NOREG},
		'{5'h02, 4'h0, 4'h3, 1'h1, 12'h008, 16'h0001, USZ_DWORD, CODE_OK},
		'{5'h02, 4'h0, 4'h4, 1'h1, 12'h000, 16'h0001, USZ_WORD, CODE_NOREG}};
	localparam logic [31:0] BASE [5] = '{32'h0000_0000, 32'h0010_0000,
		32'h0010_0080, 32'h0000_2000, 32'h0000_0000};
	// word, odd-only, dword with burst on a short-address region
	localparam logic [31:0] ATTR [4] = '{32'h0000_0000, 32'h0000_0009,
		32'h0000_0011, 32'h0000_0027};
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [11:0] regAddr = 12'h000;
	logic [31:0] regWdata = 32'h0000_0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdata;
	logic reqEnable = 1'b0;
	logic [2:0] reqRack = 3'h1;
	logic [4:0] reqSlot = 5'h00;
	logic [3:0] reqSubslot = 4'h0;
	logic reqSubslotGiven = 1'b0;
	logic [3:0] reqRegion = 4'h0;
	logic reqRegionGiven = 1'b0;
	logic [31:0] reqOffset = 32'h0000_0000;
	logic [15:0] reqUnitCount = 16'h0000;
	logic [1:0] reqUnitSize = 2'h0;
	logic [15:0] reqDest = 16'h0000;
	logic [3:0] ackDelay = 4'h0;
	logic errMode = 1'b0;
	logic busy, success, memWrite, busReq, busAckPin, busErrPin, seen;
	logic [3:0] completionCode;
	logic [15:0] memAddr, dest;
	logic [31:0] busAddr, busData, fa, memData, ua;
	logic [1:0] memUnitSize, busUnitSize, usz;
	int step = 0;
	int error_cnt = 0;
	int checks = 0;
	int wcnt = 0;
	vrr_engine vrr_engine_i (.mclk, .srst, .regAddr, .regWdata, .regWr,
		.regRd, .regRdata, .reqEnable, .reqRack, .reqSlot, .reqSubslot,
		.reqSubslotGiven, .reqRegion, .reqRegionGiven, .reqOffset,
		.reqUnitCount, .reqUnitSize, .reqDest, .busy, .success,
		.completionCode, .memWrite, .memAddr, .memData, .memUnitSize,
		.busReq, .busAddr, .busUnitSize, .busBurst(), .busWideBurst(),
		.busAm16(), .busAckPin, .busErrPin, .busData);
	vrr_bus_model vrr_bus_model_i (.mclk, .srst, .ackDelay, .errMode,
		.busReq, .busAddr, .busAckPin, .busErrPin, .busData);
	always #25 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		if (memWrite === 1'b1) begin
			`CHK(memAddr, dest + wcnt[15:0])
			`CHK(memData, (ua << 16) | (~ua & 32'h0000_FFFF))
			`CHK(memUnitSize, usz)
			ua = ua + 32'(step);
			wcnt++;
		end
		if (busReq === 1'b1 && !seen) begin
			fa = busAddr;
			seen = 1'b1;
			`CHK(busUnitSize, usz)
		end
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		regWr <= 1'b0;
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(posedge mclk);
		`CHK(regRdata, e)
	endtask
	task automatic start(input vrr_row_t r, input logic [15:0] d);
		reqSlot <= r.s;
		reqSubslot <= r.ss;
		reqSubslotGiven <= r.g;
		reqRegion <= r.r;
		reqRegionGiven <= r.g;
		reqOffset <= 32'(r.o);
		reqUnitCount <= r.n;
		reqUnitSize <= r.u;
		reqDest <= d;
		reqEnable <= 1'b1;
		wcnt = 0;
		seen = 1'b0;
		dest = d;
		ua = BASE[r.g ? r.r : 4'h1] + 32'(r.o);
		// region 2 is odd-only, so each unit steps by two
		step = r.g && r.r == 4'h2 ? 2 : 1 << r.u;
		usz = r.u;
		@(posedge mclk);
		reqEnable <= 1'b0;
	endtask
	task automatic finish(input vrr_row_t r);
		logic [31:0] ea;
		int k;
		ea = BASE[r.g ? r.r : 4'h1] + 32'(r.o);
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (busy !== 1'b0 && k < 400);
		`CHK(busy, 1'b0)
		`CHK(completionCode, r.c)
		`CHK(success, r.c == CODE_OK)
		`CHK(wcnt, r.c == CODE_OK ? int'(r.n) : 0)
		`CHK(seen ? fa : 32'h0, r.c < CODE_NOMOD ? ea : 32'h0)
	endtask
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// whole run needs about 250 cycles; sixty times that means a hang
	initial begin
		repeat (15000) @(posedge mclk);
		error_cnt++;
		complete_run();
	end
	initial begin
		vrr_row_t v;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		wr(12'h000, 32'h0000_6011);
		wr(12'h001, 32'h0000_4019);
		wr(12'h002, 32'h0000_6021);
		for (int k = 1; k < 4; k++) begin
			wr({4'h1, 8'(k - 1)}, BASE[k]);
			wr({4'h2, 8'(k - 1)}, 32'h0000_0100);
			wr({4'h3, 8'(k - 1)}, ATTR[k]);
		end
		rd(12'h101, BASE[2]);
		rd(12'h203, 32'(SIZE_RST));
		rd(12'h303, 32'(ATTR_RST));
		rd(12'h500, 32'h0000_0000);
		rd(12'h400, 32'h0000_0000);
		for (int i = 0; i < 14; i++) begin
			start(ROWS[i], 16'(i * 16));
			finish(ROWS[i]);
			$display("row test %0d done", i);
		end
		ackDelay <= 4'h9;
		start(ROWS[0], 16'h0100);
		repeat (4) @(posedge mclk);
		reqSlot <= 5'h09;
		reqEnable <= 1'b1;
		@(posedge mclk);
		reqEnable <= 1'b0;
		finish(ROWS[0]);
		$display("request during run test done");
		errMode <= 1'b1;
		v = ROWS[1];
		v.c = CODE_BUSERR;
		start(v, 16'h0200);
		finish(v);
		errMode <= 1'b0;
		rd(12'h400, 32'h0000_0001);
		$display("bus error test done");
		start(ROWS[0], 16'h0300);
		repeat (3) @(posedge mclk);
		srst <= 1'b1;
		repeat (3) @(posedge mclk);
		srst <= 1'b0;
		`CHK({busy, success, completionCode, busReq}, 7'h00)
		// tables are back at reset, so the module is gone
		v = ROWS[0];
		v.c = CODE_NOMOD;
		start(v, 16'h0400);
		finish(v);
		$display("reset test done");
		complete_run();
	end
endmodule

/* verif/vrr_properties.sv */
// port checker for the region block read engine
`timescale 1ns/100ps
module vrr_checker
	import vrr_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// request and result
	input wire logic reqEnable,
	input wire logic [15:0] reqUnitCount,
	input wire logic [1:0] reqUnitSize,
	input wire logic busy,
	input wire logic success,
	input wire logic [3:0] completionCode,
	// host memory and backplane
	input wire logic memWrite,
	input wire logic busReq,
	input wire logic [31:0] busAddr,
	input wire logic busBurst,
	input wire logic busWideBurst,
	input wire logic busAm16,
	input wire logic busErrPin
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	////////////////////////////////////////////////////////////////////////
	wire badParam = reqUnitCount == 16'h0000 || reqUnitCount > MAX_COUNT ||
		reqUnitSize == 2'h3;
	sequence take_s;
		reqEnable && !busy;
	endsequence
	// pin must outlast the synchroniser before a reaction is owed
	sequence err_held_s;
		(busReq && busErrPin) [*4];
	endsequence
	////////////////////////////////////////////////////////////////////////
	no_self_start_a: assert property (!busy && !reqEnable |=> !busy)
		else $error("busy without request");
	request_taken_a: assert property (take_s |=> busy)
		else $error("request not taken");
	param_refused_a: assert property (take_s ##0 badParam |->
		##2 !busy && completionCode == CODE_PARAM) else $error("bad count");
	result_held_a: assert property (!$fell(busy) |->
		$stable(completionCode) && $stable(success)) else $error("result moved");
	success_code_a: assert property (success |-> completionCode == CODE_OK)
		else $error("success with error code");
	fail_flag_a: assert property ($fell(busy) |->
		success == (completionCode == CODE_OK)) else $error("success mismatch");
	host_pulse_a: assert property (memWrite |=> !memWrite)
		else $error("host write too long");
	bus_in_run_a: assert property (busReq |-> busy)
		else $error("bus request while idle");
	addr_stands_a: assert property (busReq && $past(busReq) |->
		$stable(busAddr)) else $error("address moved");
	short_no_burst_a: assert property (busReq && busAm16 |->
		!busBurst && !busWideBurst) else $error("burst on short region");
	bus_error_a: assert property (err_held_s |->
		##[0:4] !busy && completionCode == CODE_BUSERR) else $error("bus error lost");
endmodule

bind vrr_engine vrr_checker vrr_checker_i (.mclk, .srst, .reqEnable,
	.reqUnitCount, .reqUnitSize, .busy, .success, .completionCode, .memWrite,
	.busReq, .busAddr, .busBurst, .busWideBurst, .busAm16, .busErrPin);
